// ---- logic/pcm_defs.svh ----
// Purpose: Constants of the pin configuration mux: offsets, fields, reset values.
// Assumes: Byte offsets relative to the block base, one 32-bit word per register.
// Notes: Included by the package and the top module.
//
// Notes on behaviour
// [RQ1] All-zero function code selects GPIO, otherwise peripheral.
// [RQ2] GPIO uses port direction; peripheral sets own.
// [RQ3] Resistor mode field, pull-up after reset.
// [RQ4] Repeater follows pin level, keeping last level.
// [RQ5] Hysteresis bit switches the input buffer.
// [RQ6] Analog mode disconnects receiver on analog pins.
// [RQ7] Software clears hysteresis and resistor when analog.
// [RQ8] I2C mode picks filter, high sink, plain.
// [RQ9] Software avoids fast-mode plus for GPIO use.
// [RQ10] Open-drain bit disables high side when output.
// [RQ11] Open-drain bit ignored on the I2C pin.
// [RQ12] One configuration register for every port pin.
// [RQ13] Location registers pick pin for multiplexed inputs.
// [RQ14] Software also selects function on chosen pin.
// [RQ15] Configuration registers reset to 0xD0 from 0x000.
// [RQ16] I2C clock pin register at 0x030 resets 0x00.
// [RQ17] Offsets 0x004 and 0x018 are reserved.
// [RQ18] Reserved offsets read zero, writes ignored.
`ifndef PCM_DEFS_SVH
`define PCM_DEFS_SVH

`define PCM_OFF_P2_6      12'h000
`define PCM_OFF_RSVD_A    12'h004
`define PCM_OFF_P2_0      12'h008
`define PCM_OFF_P0_0      12'h00C
`define PCM_OFF_P0_1      12'h010
`define PCM_OFF_P1_8      12'h014
`define PCM_OFF_RSVD_B    12'h018
`define PCM_OFF_P0_2      12'h01C
`define PCM_OFF_P2_7      12'h020
`define PCM_OFF_P2_8      12'h024
`define PCM_OFF_P2_1      12'h028
`define PCM_OFF_P0_3      12'h02C
`define PCM_OFF_P0_4      12'h030
`define PCM_OFF_LOC_SCK   12'h0B0
`define PCM_OFF_LOC_DSR   12'h0B4
`define PCM_OFF_LOC_DCD   12'h0B8
`define PCM_OFF_LOC_RI    12'h0BC

`define PCM_ADDR_MSB      11

`define PCM_CFG_W         11
`define PCM_FUNCTION_SELECT_LSB      0
`define PCM_FUNCTION_SELECT_MSB      2
`define PCM_MODE_LSB      3
`define PCM_MODE_MSB      4
`define PCM_HYS_BIT       5
`define PCM_DIGITAL_BIT   7
`define PCM_I2C_LSB       8
`define PCM_I2C_MSB       9
`define PCM_OD_BIT        10

`define PCM_CFG_RESET     11'h0D0
`define PCM_CFG_RESET_I2C 11'h000
`define PCM_FUNCTION_SELECT_GPIO     3'h0
`define PCM_FUNCTION_SELECT_I2C      3'h1

`define PCM_LOC_W         2
`define PCM_LOC_RESET     2'h0
`define PCM_NLOC          4
`define PCM_LOC_SCK       0
`define PCM_LOC_DSR       1
`define PCM_LOC_DCD       2
`define PCM_LOC_RI        3

`define PCM_I2C_PIN       10
`define PCM_ANALOG_MASK   11'h208
`define PCM_NPIN          11

`endif

// ---- logic/pcm_pkg.sv ----
// Purpose: Types shared by the pin configuration mux.
// Assumes: pcm_defs.svh supplies the numeric constants.
// Notes: Location table gives the pin index for each location code.
`include "pcm_defs.svh"

package pcm_pkg;

	typedef enum logic [1:0] {
		PCM_PULL_NONE,
		PCM_PULL_DOWN,
		PCM_PULL_UP,
		PCM_PULL_REPEAT
	} pcm_pull_t;

	typedef enum logic [1:0] {
		PCM_I2C_STD_FAST,
		PCM_I2C_PLAIN_IO,
		PCM_I2C_FAST_PLUS,
		PCM_I2C_RESERVED
	} pcm_i2c_t;

	typedef enum logic [1:0] {
		PCM_KIND_NONE,
		PCM_KIND_CFG,
		PCM_KIND_LOC
	} pcm_kind_t;

	// Candidate pins for each multiplexed input, indexed by location code.
	localparam int unsigned PCM_LOC_PIN [`PCM_NLOC][4] = '{
		'{8, 1, 5, 8},
		'{8, 3, 2, 8},
		'{1, 4, 6, 1},
		'{9, 7, 0, 9}
	};

endpackage : pcm_pkg

// ---- logic/pcm_top.sv ----
// Purpose: Per-pin configuration registers and pad control for eleven port pins.
// Assumes: AHB-Lite slave, single word transfers, one 100 MHz clock.
// Notes: Writes take no wait state; reads take one, so read data is never stale.
`timescale 1ns/1ps
`default_nettype none
`include "pcm_defs.svh"

module pcm_top #(
	parameter int NPIN = `PCM_NPIN
) (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output var  logic              hreadyout,
	output var  logic              hresp,
	output var  logic [31:0]       hrdata,
	// Pad cells
	input  wire logic [NPIN-1:0]   pad_in,
	output var  logic [NPIN-1:0]   port_pin_out,
	output var  logic [NPIN-1:0]   port_pin_oe,
	output var  logic [NPIN-1:0]   pull_up_en,
	output var  logic [NPIN-1:0]   pull_down_en,
	output var  logic [NPIN-1:0]   hysteresis_enable,
	output var  logic [NPIN-1:0]   receiver_en,
	output var  logic [NPIN-1:0]   i2c_filter_en,
	output var  logic [NPIN-1:0]   i2c_high_sink,
	// GPIO logic
	input  wire logic [NPIN-1:0]   gpio_out,
	input  wire logic [NPIN-1:0]   port_direction,
	output var  logic [NPIN-1:0]   gpio_in,
	// Peripheral functions
	input  wire logic [NPIN-1:0]   periph_out,
	input  wire logic [NPIN-1:0]   periph_oe,
	output var  logic [NPIN-1:0]   periph_in,
	output var  logic              sync_serial_clock_input,
	output var  logic              dsr_input,
	output var  logic              carrier_detect_input,
	output var  logic              ring_indicate_input
);
	import pcm_pkg::*;

	logic [`PCM_CFG_W-1:0]  cfg_reg [NPIN];
	logic [`PCM_LOC_W-1:0]  loc_reg [`PCM_NLOC];
	logic [NPIN-1:0]        sync1_reg;
	logic [NPIN-1:0]        sync2_reg;
	logic [NPIN-1:0]        sync3_reg;
	logic [NPIN-1:0]        level_reg;
	logic                   wr_pend_reg;
	logic                   rd_pend_reg;
	pcm_kind_t              kind_reg;
	logic [3:0]             idx_reg;
	pcm_kind_t              kind_next;
	logic [3:0]             idx_next;
	logic                   take;
	logic [NPIN-1:0]        rx_on;
	logic [NPIN-1:0]        pin_data;
	logic [31:0]            rd_next;

	assign take = hsel && hready && htrans[1];

	// Address decode; reserved and unmapped offsets fall to PCM_KIND_NONE.
	always_comb
	begin
		kind_next = PCM_KIND_CFG;
		idx_next  = 4'h0;
		unique case (haddr[`PCM_ADDR_MSB:0])
			`PCM_OFF_P2_6:    idx_next = 4'h0; // see [RQ12]
			`PCM_OFF_P2_0:    idx_next = 4'h1;
			`PCM_OFF_P0_0:    idx_next = 4'h2;
			`PCM_OFF_P0_1:    idx_next = 4'h3;
			`PCM_OFF_P1_8:    idx_next = 4'h4;
			`PCM_OFF_P0_2:    idx_next = 4'h5;
			`PCM_OFF_P2_7:    idx_next = 4'h6;
			`PCM_OFF_P2_8:    idx_next = 4'h7;
			`PCM_OFF_P2_1:    idx_next = 4'h8;
			`PCM_OFF_P0_3:    idx_next = 4'h9;
			`PCM_OFF_P0_4:    idx_next = 4'hA;
			`PCM_OFF_LOC_SCK:
			begin
				kind_next = PCM_KIND_LOC;
				idx_next  = 4'h0;
			end
			`PCM_OFF_LOC_DSR:
			begin
				kind_next = PCM_KIND_LOC;
				idx_next  = 4'h1;
			end
			`PCM_OFF_LOC_DCD:
			begin
				kind_next = PCM_KIND_LOC;
				idx_next  = 4'h2;
			end
			`PCM_OFF_LOC_RI:
			begin
				kind_next = PCM_KIND_LOC;
				idx_next  = 4'h3;
			end
			default:          kind_next = PCM_KIND_NONE; // see [RQ17]
		endcase
		if (haddr[31:`PCM_ADDR_MSB+1] != '0)
		begin
			kind_next = PCM_KIND_NONE;
		end
	end

	// Address phase capture; a read inserts one wait state.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			kind_reg    <= PCM_KIND_NONE;
			idx_reg     <= 4'h0;
			hreadyout   <= 1'b1;
		end
		else if (rd_pend_reg)
		begin
			rd_pend_reg <= 1'b0;
			hreadyout   <= 1'b1;
		end
		else
		begin
			wr_pend_reg <= take && hwrite;
			rd_pend_reg <= take && !hwrite;
			hreadyout   <= !(take && !hwrite);
			if (take)
			begin
				kind_reg <= kind_next;
				idx_reg  <= idx_next;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hresp <= 1'b0;
		end
		else
		begin
			hresp <= 1'b0;
		end
	end

	// Read data is built in the wait state, after any earlier write has landed.
	always_comb
	begin
		rd_next = 32'h0000_0000; // see [RQ18]
		unique case (kind_reg)
			PCM_KIND_CFG: rd_next[`PCM_CFG_W-1:0] = cfg_reg[idx_reg];
			PCM_KIND_LOC: rd_next[`PCM_LOC_W-1:0] = loc_reg[idx_reg[1:0]];
			default:      rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h0000_0000;
		end
		else if (rd_pend_reg)
		begin
			hrdata <= rd_next;
		end
	end

	// Configuration words; the I2C clock pin has its own reset value.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < NPIN; i++)
			begin
				cfg_reg[i] <= (i == `PCM_I2C_PIN) ? `PCM_CFG_RESET_I2C : `PCM_CFG_RESET; // see [RQ15] [RQ16]
			end
		end
		else if (wr_pend_reg && kind_reg == PCM_KIND_CFG)
		begin
			cfg_reg[idx_reg] <= hwdata[`PCM_CFG_W-1:0]; // see [RQ12]
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < `PCM_NLOC; i++)
			begin
				loc_reg[i] <= `PCM_LOC_RESET;
			end
		end
		else if (wr_pend_reg && kind_reg == PCM_KIND_LOC)
		begin
			loc_reg[idx_reg[1:0]] <= hwdata[`PCM_LOC_W-1:0]; // see [RQ13]
		end
	end

	// Pad inputs cross in from outside; a change counts once stages two and three agree.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			level_reg <= '0;
		end
		else
		begin
			sync1_reg <= pad_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			for (int i = 0; i < NPIN; i++)
			begin
				if (sync2_reg[i] == sync3_reg[i])
				begin
					level_reg[i] <= sync3_reg[i];
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_pin
			localparam bit IS_I2C    = (g == `PCM_I2C_PIN);
			localparam bit IS_ANALOG = ((`PCM_ANALOG_MASK >> g) & 1) != 0;

			logic [2:0]  function_select;
			pcm_pull_t   pull;
			pcm_i2c_t    i2c;
			logic        is_gpio;
			logic        dir_out;
			logic        dat_out;
			logic        od_eff;
			logic        i2c_function_select;

			assign function_select     = cfg_reg[g][`PCM_FUNCTION_SELECT_MSB:`PCM_FUNCTION_SELECT_LSB];
			assign pull     = pcm_pull_t'(cfg_reg[g][`PCM_MODE_MSB:`PCM_MODE_LSB]);
			assign i2c      = pcm_i2c_t'(cfg_reg[g][`PCM_I2C_MSB:`PCM_I2C_LSB]);
			assign is_gpio  = (function_select == `PCM_FUNCTION_SELECT_GPIO); // see [RQ1]
			assign dir_out  = is_gpio ? port_direction[g] : periph_oe[g]; // see [RQ2]
			assign dat_out  = is_gpio ? gpio_out[g] : periph_out[g]; // see [RQ1]
			// The I2C pad is always open-drain, so the bit is ignored there.
			assign od_eff   = IS_I2C ? 1'b1 : cfg_reg[g][`PCM_OD_BIT]; // see [RQ10] [RQ11]
			assign i2c_function_select = IS_I2C && (function_select == `PCM_FUNCTION_SELECT_I2C);
			// Only pins with an analog function honour the digital bit.
			assign rx_on[g] = IS_ANALOG ? cfg_reg[g][`PCM_DIGITAL_BIT] : 1'b1; // see [RQ6]
			assign pin_data[g] = level_reg[g] & rx_on[g];

			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					port_pin_out[g]      <= 1'b0;
					port_pin_oe[g]       <= 1'b0;
					pull_up_en[g]        <= 1'b0;
					pull_down_en[g]      <= 1'b0;
					hysteresis_enable[g] <= 1'b0;
					receiver_en[g]       <= 1'b0;
					i2c_filter_en[g]     <= 1'b0;
					i2c_high_sink[g]     <= 1'b0;
					gpio_in[g]           <= 1'b0;
					periph_in[g]         <= 1'b0;
				end
				else
				begin
					port_pin_out[g]      <= od_eff ? 1'b0 : dat_out; // see [RQ10]
					port_pin_oe[g]       <= dir_out && !(od_eff && dat_out); // see [RQ10]
					// Repeater holds an undriven input at the last level seen.
					pull_up_en[g]        <= (pull == PCM_PULL_UP) ||
						(pull == PCM_PULL_REPEAT && level_reg[g]); // see [RQ3] [RQ4]
					pull_down_en[g]      <= (pull == PCM_PULL_DOWN) ||
						(pull == PCM_PULL_REPEAT && !level_reg[g]); // see [RQ3] [RQ4]
					hysteresis_enable[g] <= cfg_reg[g][`PCM_HYS_BIT]; // see [RQ5]
					receiver_en[g]       <= rx_on[g]; // see [RQ6]
					i2c_filter_en[g]     <= i2c_function_select &&
						(i2c == PCM_I2C_STD_FAST || i2c == PCM_I2C_FAST_PLUS); // see [RQ8]
					i2c_high_sink[g]     <= i2c_function_select && (i2c == PCM_I2C_FAST_PLUS); // see [RQ8]
					gpio_in[g]           <= is_gpio ? pin_data[g] : 1'b0;
					periph_in[g]         <= is_gpio ? 1'b0 : pin_data[g];
				end
			end
		end
	endgenerate

	// A multiplexed input only sees its pin once that pin is off GPIO; otherwise it idles high.
	function automatic logic pcm_loc_level(input int unsigned fn);
		int unsigned p;
		p = PCM_LOC_PIN[fn][loc_reg[fn]];
		if (cfg_reg[p][`PCM_FUNCTION_SELECT_MSB:`PCM_FUNCTION_SELECT_LSB] != `PCM_FUNCTION_SELECT_GPIO)
		begin
			return pin_data[p]; // see [RQ13] [RQ14]
		end
		return 1'b1;
	endfunction : pcm_loc_level

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync_serial_clock_input <= 1'b1;
			dsr_input               <= 1'b1;
			carrier_detect_input    <= 1'b1;
			ring_indicate_input     <= 1'b1;
		end
		else
		begin
			sync_serial_clock_input <= pcm_loc_level(`PCM_LOC_SCK); // see [RQ13]
			dsr_input               <= pcm_loc_level(`PCM_LOC_DSR);
			carrier_detect_input    <= pcm_loc_level(`PCM_LOC_DCD);
			ring_indicate_input     <= pcm_loc_level(`PCM_LOC_RI);
		end
	end

endmodule : pcm_top

`default_nettype wire

// ---- verification/pcm_sva.sv ----
// Purpose: Port assertions for the pin configuration mux.
// Assumes: One clock, reset active low.
// Notes: Bound to every pcm_top.
`timescale 1ns/1ps
`default_nettype none
module pcm_sva #(
	parameter int NPIN = 11
) (
	// Bus
	input wire logic            hclk,
	input wire logic            hresetn,
	input wire logic            hsel,
	input wire logic            hready,
	input wire logic [1:0]      htrans,
	input wire logic            hwrite,
	input wire logic            hreadyout,
	input wire logic            hresp,
	// Pads
	input wire logic [NPIN-1:0] port_pin_out,
	input wire logic [NPIN-1:0] pull_up_en,
	input wire logic [NPIN-1:0] pull_down_en,
	input wire logic [NPIN-1:0] receiver_en,
	input wire logic [NPIN-1:0] i2c_filter_en,
	input wire logic [NPIN-1:0] i2c_high_sink,
	input wire logic [NPIN-1:0] gpio_in,
	input wire logic [NPIN-1:0] periph_in
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_RESP_OKAY: assert property (hresp == 1'b0)
		else $error("Bus response not OKAY");
	AST_READ_WAIT: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("Read wait state wrong");
	AST_RESET_CFG: assert property ($rose(hresetn) |=> pull_up_en == 11'h3ff && receiver_en == 11'h7ff)
		else $error("Pad controls not at reset configuration");
	AST_RX_ANALOG: assert property ($past(hresetn) |-> (~receiver_en & ~11'h208) == 11'h000)
		else $error("Receiver off on a digital-only pin");
	AST_PULL_EXCL: assert property ((pull_up_en & pull_down_en) == '0)
		else $error("Pull-up and pull-down both on");
	AST_I2C_ONLY: assert property (((i2c_high_sink | i2c_filter_en) & {1'b0, {(NPIN-1){1'b1}}}) == '0)
		else $error("I2C pad control on a non-I2C pin");
	AST_OD_I2C: assert property (port_pin_out[NPIN-1] == 1'b0)
		else $error("I2C pin drives high");
	AST_IN_SIDE: assert property ((gpio_in & periph_in) == '0)
		else $error("Pin level sent to GPIO and peripheral");
endmodule : pcm_sva
bind pcm_top pcm_sva #(.NPIN(NPIN)) u_sva (.hclk, .hresetn, .hsel, .hready, .htrans, .hwrite,
	.hreadyout, .hresp, .port_pin_out, .pull_up_en, .pull_down_en, .receiver_en,
	.i2c_filter_en, .i2c_high_sink, .gpio_in, .periph_in);
`default_nettype wire

// ---- verification/pcm_pad_model.sv ----
// Purpose: Pad cells seen from outside the mux.
// Assumes: Eleven pins.
// Notes: A pin nobody drives or pulls toggles every clock.
`timescale 1ns/1ps
`default_nettype none
module pcm_pad_model (
	// Clock
	input  wire logic        hclk,
	// Drive and pulls from the mux
	input  wire logic [10:0] drv_en,
	input  wire logic [10:0] drv_val,
	input  wire logic [10:0] pull_up,
	input  wire logic [10:0] pull_down,
	// External driver
	input  wire logic [10:0] ext_en,
	input  wire logic [10:0] ext_val,
	output var  logic [10:0] pad
);
	logic [10:0] float_reg = 11'h555;
	always_ff @(posedge hclk)
	begin
		float_reg <= ~float_reg;
	end
	// Pulls decide an undriven pin, so a repeater keeps the last level.
	assign pad = drv_en & drv_val | ~drv_en & (ext_en & ext_val
		| ~ext_en & (pull_up | ~pull_down & float_reg));
endmodule : pcm_pad_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the pin configuration mux.
// Assumes: Pads modelled by pcm_pad_model.
// Notes: Random register traffic, then directed pad cases.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pcm_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic        hreadyout, hresp;
	logic [31:0] hrdata, rd, seed = 32'h6e30;
	logic [10:0] pad_in, port_pin_out, port_pin_oe, pull_up_en, pull_down_en, gpio_in;
	logic [10:0] hysteresis_enable, receiver_en, i2c_filter_en, i2c_high_sink, periph_in;
	logic [10:0] ext_en = '0, ext_val = '0, gpio_out = '0, port_direction = '0;
	logic [10:0] periph_out = '0, periph_oe = '0;
	logic        sync_serial_clock_input, dsr_input, carrier_detect_input, ring_indicate_input;
	logic [31:0] mem [64];
	int          fails = 0, n_tests = 0;
	logic [11:0] off [11] = '{12'h000, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h01c,
		12'h020, 12'h024, 12'h028, 12'h02c, 12'h030};
	// Config word in [15:5], expected oe, out, pull-up, pull-down, hysteresis in [4:0].
	logic [15:0] pt [6] = '{16'h0018, 16'h8102, 16'h061d, 16'h0020, 16'h031c, 16'h8304};
	logic [1:0]  i2c_tab [4] = '{2'b10, 2'b00, 2'b11, 2'b00};
	always #5 hclk = ~hclk;
	pcm_pad_model u_pads (.hclk, .drv_en(port_pin_oe), .drv_val(port_pin_out),
		.pull_up(pull_up_en), .pull_down(pull_down_en), .ext_en, .ext_val, .pad(pad_in));
	pcm_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .pad_in, .port_pin_out,
		.port_pin_oe, .pull_up_en, .pull_down_en, .hysteresis_enable, .receiver_en,
		.i2c_filter_en, .i2c_high_sink, .gpio_out, .port_direction, .gpio_in, .periph_out,
		.periph_oe, .periph_in, .sync_serial_clock_input, .dsr_input,
		.carrier_detect_input, .ring_indicate_input);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [31:0] msk(logic [11:0] a);
		msk = (a >= 12'h0b0 && a <= 12'h0bc) ? 32'h0000_0003 : 32'h0000_0000;
		foreach (off[i])
			if (off[i] == a)
				msk = 32'h0000_07ff;
	endfunction : msk
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// A hung bus is counted and ends the run.
	task automatic wrdy();
		int i;
		i = 0;
		do
		begin
			@(posedge hclk);
			i++;
		end
		while (hreadyout !== 1'b1 && i < 20);
		if (hreadyout !== 1'b1)
		begin
			fails++;
			stop_test();
		end
	endtask : wrdy
	task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0_0000, a};
		wrdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wrdy();
		rd = hrdata;
	endtask : bus
	task automatic wcfg(logic [11:0] a, logic [31:0] d, int n);
		bus(1'b1, a, d);
		repeat (n) @(posedge hclk);
		#1;
	endtask : wcfg
	task automatic rst();
		hresetn <= 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (mem[i])
			mem[i] = (msk(12'(i * 4)) == 32'h0000_07ff && i != 12) ? 32'h0000_00d0 : '0;
	endtask : rst
	initial
	begin
		logic [11:0] a;
		logic [31:0] d;
		rst();
		for (int i = 0; i < 64; i++)
		begin
			bus(1'b0, 12'(i * 4), '0);
			chk("reset value", mem[i], rd);
		end
		for (int i = 0; i < 60; i++)
		begin
			d = rnd();
			a = {4'h0, d[5:0], 2'b00};
			gpio_out <= d[10:0];
			ext_en <= d[26:16];
			ext_val <= d[31:21];
			d = rnd();
			bus(1'b1, a, d);
			mem[a[7:2]] = d & msk(a);
			bus(1'b0, a, '0);
			chk("readback", mem[a[7:2]], rd);
		end
		rst();
		gpio_out <= 11'h7ff;
		port_direction <= 11'h001;
		ext_en <= '0;
		foreach (pt[i])
		begin
			wcfg(12'h000, {21'h0, pt[i][15:5]}, 8);
			chk("pin0 pad", {27'h0, pt[i][4:0]}, {27'h0, port_pin_oe[0], port_pin_out[0],
				pull_up_en[0], pull_down_en[0], hysteresis_enable[0]});
		end
		wcfg(12'h010, 32'h0000_0000, 0);
		wcfg(12'h000, 32'h0000_0050, 2);
		chk("receiver", 32'h1, {30'h0, receiver_en[3], receiver_en[0]});
		for (int m = 0; m < 4; m++)
		begin
			wcfg(12'h030, 32'(m) << 8 | 32'h1, 2);
			chk("i2c mode", {30'h0, i2c_tab[m]}, {30'h0, i2c_filter_en[10], i2c_high_sink[10]});
		end
		wcfg(12'h030, 32'h0, 2);
		chk("i2c pin as gpio", 32'h0, {30'h0, i2c_filter_en[10], i2c_high_sink[10]});
		wcfg(12'h0b0, 32'h1, 0);
		wcfg(12'h008, 32'h1, 0);
		ext_en <= 11'h002;
		for (int k = 0; k < 2; k++)
		begin
			ext_val <= {9'h0, k[0], 1'b0};
			repeat (8) @(posedge hclk);
			#1;
			chk("serial clock source", {31'h0, k[0]}, {31'h0, sync_serial_clock_input});
		end
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
